// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
  import tca_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic                sys_clk_in = 1'b0;
  logic                rst_in     = 1'b1;
  logic                awvalid    = 1'b0;
  logic                wvalid     = 1'b0;
  logic                bready     = 1'b0;
  logic                arvalid    = 1'b0;
  logic                rready     = 1'b0;
  logic [ADDR_W-1:0]   awaddr     = 16'h0000;
  logic [ADDR_W-1:0]   araddr     = 16'h0000;
  logic [DATA_W-1:0]   wdata      = 32'h00000000;
  logic [3:0]          wstrb      = 4'h0;
  logic [TEMP_W-1:0]   sens       = 16'h0000;
  logic                awready, wready, bvalid, arready, rvalid, alarm, irq;
  logic [1:0]          bresp, rresp;
  logic [DATA_W-1:0]   rdata;
  logic [TEMP_W-1:0]   ch0_t, ch1_t, sys_t;
  logic [TEMP_W-1:0]   tv [5] = '{16'h118D, 16'h118E, 16'hF833, 16'hF832, 16'h0000};
  logic                ta [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  int                  err_total  = 0;
  int                  n_compared = 0;

  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  tca_top i_dut (
    .sys_clk_in                       (sys_clk_in),
    .rst_in                           (rst_in),
    .s_axi_awvalid_in                 (awvalid),
    .s_axi_awready_out                (awready),
    .s_axi_awaddr_in                  (awaddr),
    .s_axi_wvalid_in                  (wvalid),
    .s_axi_wready_out                 (wready),
    .s_axi_wdata_in                   (wdata),
    .s_axi_wstrb_in                   (wstrb),
    .s_axi_bvalid_out                 (bvalid),
    .s_axi_bready_in                  (bready),
    .s_axi_bresp_out                  (bresp),
    .s_axi_arvalid_in                 (arvalid),
    .s_axi_arready_out                (arready),
    .s_axi_araddr_in                  (araddr),
    .s_axi_rvalid_out                 (rvalid),
    .s_axi_rready_in                  (rready),
    .s_axi_rdata_out                  (rdata),
    .s_axi_rresp_out                  (rresp),
    .temp_sensor_in                   (sens),
    .phase_loop_channel_zero_temp_out (ch0_t),
    .phase_loop_channel_one_temp_out  (ch1_t),
    .system_clock_path_temp_out       (sys_t),
    .temp_alarm_out                   (alarm),
    .irq_out                          (irq)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Handshakes are judged on the falling edge, where the values equal
  // those the next rising edge samples, so no race with the design.
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [1:0] exp);
    logic       a_t;
    logic       w_t;
    logic       b_t;
    logic [1:0] resp;
    b_t = 1'b0;
    resp = 2'h0;
    @(posedge sys_clk_in);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t) begin
      @(negedge sys_clk_in);
      a_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid & bready;
      resp = bresp;
      @(posedge sys_clk_in);
      if (a_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end
    chk({30'h0, resp}, {30'h0, exp});
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [1:0] exp);
    logic              a_t;
    logic              r_t;
    logic [1:0]        resp;
    logic [DATA_W-1:0] data;
    r_t = 1'b0;
    resp = 2'h0;
    data = 32'h0;
    @(posedge sys_clk_in);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t) begin
      @(negedge sys_clk_in);
      a_t = arvalid & arready;
      r_t = rvalid & rready;
      resp = rresp;
      data = rdata;
      @(posedge sys_clk_in);
      if (a_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end
    chk(data, {24'h000000, d});
    chk({30'h0, resp}, {30'h0, exp});
  endtask

  task automatic settle();
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
  endtask

  task automatic set_sens(input logic [TEMP_W-1:0] v);
    @(posedge sys_clk_in);
    sens <= v;
    settle();
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rd(IDX_SRC, 8'h00, RESP_OKAY);
    rd(IDX_LOW_LO, 8'h00, RESP_OKAY);
    wr(IDX_SRC, 8'hFF, RESP_OKAY);
    rd(IDX_SRC, 8'h07, RESP_OKAY);
    wr(14'h2920, 8'h5A, RESP_SLVERR);
    rd(14'h2920, 8'h00, RESP_SLVERR);
    wr(IDX_EXT_LO, 8'h33, RESP_OKAY);
    wr(IDX_EXT_HI, 8'hF8, RESP_OKAY);
    wr(IDX_IRQ_EN, 8'h01, RESP_OKAY);
    set_sens(16'h118D);
    // External value still waits for the update, so all paths show zero
    chk({16'h0, sys_t}, 32'h0);
    chk({31'h0, alarm}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(IDX_STATUS, 8'h09, RESP_OKAY);
    wr(IDX_IRQ_CLR, 8'h07, RESP_OKAY);
    settle();
    chk({31'h0, irq}, 32'h0);
    wr(IDX_UPDATE, 8'h01, RESP_OKAY);
    settle();
    chk({16'h0, ch0_t}, 32'hF833);
    for (int i = 0; i < 3; i++) begin
      wr(IDX_SRC, 8'h01 << i, RESP_OKAY);
      settle();
      chk({16'h0, ch1_t}, (i == 2) ? 32'hF833 : 32'h118D);
      chk({16'h0, ch0_t}, (i == 1) ? 32'hF833 : 32'h118D);
      chk({16'h0, sys_t}, (i == 0) ? 32'hF833 : 32'h118D);
    end
    wr(IDX_LOW_LO, 8'h33, RESP_OKAY);
    wr(IDX_LOW_HI, 8'hF8, RESP_OKAY);
    wr(IDX_HIGH_LO, 8'h8D, RESP_OKAY);
    wr(IDX_HIGH_HI, 8'h11, RESP_OKAY);
    rd(IDX_LOW_HI, 8'hF8, RESP_OKAY);
    rd(IDX_HIGH_LO, 8'h8D, RESP_OKAY);
    settle();
    chk({31'h0, alarm}, 32'h1);
    wr(IDX_UPDATE, 8'h01, RESP_OKAY);
    // Limits are -15.6 and +35.1 degrees; probe both edges, strict compare
    for (int k = 0; k < 5; k++) begin
      set_sens(tv[k]);
      chk({31'h0, alarm}, {31'h0, ta[k]});
    end
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_CLR, 8'h07, RESP_OKAY);
    settle();
    chk({31'h0, irq}, 32'h0);
    rd(IDX_STATUS, 8'h00, RESP_OKAY);
    wr(IDX_IRQ_EN, 8'h00, RESP_OKAY);
    set_sens(16'hF832);
    chk({31'h0, irq}, 32'h0);
    rd(IDX_STATUS, 8'h09, RESP_OKAY);
    // Enabling a bit that is already set raises the interrupt at once
    wr(IDX_IRQ_EN, 8'h01, RESP_OKAY);
    settle();
    chk({31'h0, irq}, 32'h1);
    rd(IDX_IRQ_EN, 8'h01, RESP_OKAY);
    // Just above the active low limit, then raise that limit to zero
    set_sens(16'hF834);
    chk({31'h0, alarm}, 32'h0);
    rd(IDX_SENS_HI, 8'hF8, RESP_OKAY);
    rd(IDX_SENS_LO, 8'h34, RESP_OKAY);
    rd(IDX_EXT_HI, 8'hF8, RESP_OKAY);
    wr(IDX_LOW_LO, 8'h00, RESP_OKAY);
    wr(IDX_LOW_HI, 8'h00, RESP_OKAY);
    settle();
    chk({31'h0, alarm}, 32'h0);
    wr(IDX_UPDATE, 8'h01, RESP_OKAY);
    settle();
    chk({31'h0, alarm}, 32'h1);
    final_report();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    err_total++;
    final_report();
  end
endmodule // tb

// file: hw/tca_src_mux.sv
`timescale 1ns/1ps
module tca_src_mux #(
  parameter int W = 16
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic         sel_ext_in,
  input  wire logic [W-1:0] int_temp_in,
  input  wire logic [W-1:0] ext_temp_in,
  output logic      [W-1:0] temp_out
);
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      temp_out <= '0;
    end else begin
      temp_out <= sel_ext_in ? ext_temp_in : int_temp_in;
    end
  end
endmodule // tca_src_mux

// file: hw/tca_top.sv
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module tca_top (
  input  wire logic                          sys_clk_in,
  input  wire logic                          rst_in,
  input  wire logic                          s_axi_awvalid_in,
  output logic                               s_axi_awready_out,
  input  wire logic [tca_pkg::ADDR_W-1:0]    s_axi_awaddr_in,
  input  wire logic                          s_axi_wvalid_in,
  output logic                               s_axi_wready_out,
  input  wire logic [tca_pkg::DATA_W-1:0]    s_axi_wdata_in,
  input  wire logic [3:0]                    s_axi_wstrb_in,
  output logic                               s_axi_bvalid_out,
  input  wire logic                          s_axi_bready_in,
  output logic [1:0]                         s_axi_bresp_out,
  input  wire logic                          s_axi_arvalid_in,
  output logic                               s_axi_arready_out,
  input  wire logic [tca_pkg::ADDR_W-1:0]    s_axi_araddr_in,
  output logic                               s_axi_rvalid_out,
  input  wire logic                          s_axi_rready_in,
  output logic [tca_pkg::DATA_W-1:0]         s_axi_rdata_out,
  output logic [1:0]                         s_axi_rresp_out,
  input  wire logic [tca_pkg::TEMP_W-1:0]    temp_sensor_in,
  output logic [tca_pkg::TEMP_W-1:0]         phase_loop_channel_zero_temp_out,
  output logic [tca_pkg::TEMP_W-1:0]         phase_loop_channel_one_temp_out,
  output logic [tca_pkg::TEMP_W-1:0]         system_clock_path_temp_out,
  output logic                               temp_alarm_out,
  output logic                               irq_out
);
  import tca_pkg::*;

  logic              aw_have_q;
  logic              w_have_q;
  logic [IDX_W-1:0]  aw_idx_q;
  logic [7:0]        wbyte_q;
  logic              wlane_q;
  logic              wr_go;
  logic              wr_en;
  logic              upd_go;
  logic [IDX_W-1:0]  rd_idx_q;
  logic [DATA_W-1:0] rd_data;
  logic              rd_hit;
  tca_src_t          src_q;
  tca_temps_t        shd_q;
  tca_temps_t        act_q;
  logic              alarm_d;
  logic [STS_W-1:0]  sts_q;
  logic [STS_W-1:0]  sts_d;
  logic [STS_W-1:0]  evt;
  logic [STS_W-1:0]  clr;
  logic [STS_W-1:0]  irq_en_q;
  logic [STS_W-1:0]  irq_en_d;
  tca_src_t          wsrc;

  function automatic logic mapped(input logic [IDX_W-1:0] idx);
    mapped = (idx >= IDX_EXT_LO && idx <= IDX_HIGH_HI) ||
             (idx >= IDX_UPDATE && idx <= IDX_SENS_HI);
  endfunction

  // --------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid_out;
  // Only byte lane 0 carries register data; other lanes are ignored
  assign wr_en = wr_go && wlane_q;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      aw_have_q         <= 1'b0;
      aw_idx_q          <= '0;
      s_axi_awready_out <= 1'b1;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_have_q         <= 1'b1;
      aw_idx_q          <= s_axi_awaddr_in[ADDR_W-1:2];
      s_axi_awready_out <= 1'b0;
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_awready_out <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      w_have_q         <= 1'b0;
      wbyte_q          <= '0;
      wlane_q          <= 1'b0;
      s_axi_wready_out <= 1'b1;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_have_q         <= 1'b1;
      wbyte_q          <= s_axi_wdata_in[7:0];
      wlane_q          <= s_axi_wstrb_in[0];
      s_axi_wready_out <= 1'b0;
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_wready_out <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------
  // Reserved bits of the written byte are dropped, so they stay zero
  assign wsrc = tca_src_t'(wbyte_q);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      src_q <= SRC_RST;
    end else if (wr_en && aw_idx_q == IDX_SRC) begin
      src_q.ch1 <= wsrc.ch1;
      src_q.ch0 <= wsrc.ch0;
      src_q.sys <= wsrc.sys;
    end
  end

  // Writes land in the shadow copy only; the alarm sees them only after an update command
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      shd_q <= {TEMP_RST, TEMP_RST, TEMP_RST};
    end else if (wr_en) begin
      unique case (aw_idx_q)
        IDX_EXT_LO:  shd_q.ext[7:0]   <= wbyte_q;
        IDX_EXT_HI:  shd_q.ext[15:8]  <= wbyte_q;
        IDX_LOW_LO:  shd_q.low[7:0]   <= wbyte_q;
        IDX_LOW_HI:  shd_q.low[15:8]  <= wbyte_q;
        IDX_HIGH_LO: shd_q.high[7:0]  <= wbyte_q;
        IDX_HIGH_HI: shd_q.high[15:8] <= wbyte_q;
        default: ;
      endcase
    end
  end

  // Update command is self-clearing: nothing is stored, it reads zero
  assign upd_go = wr_en && aw_idx_q == IDX_UPDATE && wbyte_q[UPD_BIT];

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      act_q <= {TEMP_RST, TEMP_RST, TEMP_RST};
    end else if (upd_go) begin
      act_q <= shd_q;
    end
  end

  // Next-state enable feeds the irq flop, so irq never lags an enable write
  always_comb begin
    irq_en_d = irq_en_q;
    if (wr_en && aw_idx_q == IDX_IRQ_EN) begin
      irq_en_d = wbyte_q[STS_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      irq_en_q <= STS_RST;
    end else begin
      irq_en_q <= irq_en_d;
    end
  end

  // --------------------------------------------------------------
  // Compensation sources
  // --------------------------------------------------------------
  tca_src_mux #(.W(TEMP_W)) u_mux_ch1 (
    .sys_clk_in  (sys_clk_in),
    .rst_in      (rst_in),
    .sel_ext_in  (src_q.ch1),
    .int_temp_in (temp_sensor_in),
    .ext_temp_in (act_q.ext),
    .temp_out    (phase_loop_channel_one_temp_out)
  );

  tca_src_mux #(.W(TEMP_W)) u_mux_ch0 (
    .sys_clk_in  (sys_clk_in),
    .rst_in      (rst_in),
    .sel_ext_in  (src_q.ch0),
    .int_temp_in (temp_sensor_in),
    .ext_temp_in (act_q.ext),
    .temp_out    (phase_loop_channel_zero_temp_out)
  );

  tca_src_mux #(.W(TEMP_W)) u_mux_sys (
    .sys_clk_in  (sys_clk_in),
    .rst_in      (rst_in),
    .sel_ext_in  (src_q.sys),
    .int_temp_in (temp_sensor_in),
    .ext_temp_in (act_q.ext),
    .temp_out    (system_clock_path_temp_out)
  );

  // --------------------------------------------------------------
  // Alarm and interrupt
  // --------------------------------------------------------------
  // Signed compare keeps negative temperatures below positive limits
  assign alarm_d = ($signed(temp_sensor_in) < $signed(act_q.low)) ||
                   ($signed(temp_sensor_in) > $signed(act_q.high));

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      temp_alarm_out <= 1'b0;
    end else begin
      temp_alarm_out <= alarm_d;
    end
  end

  always_comb begin
    evt                = '0;
    evt[STS_ALARM_ON]  = alarm_d && !temp_alarm_out;
    evt[STS_ALARM_OFF] = !alarm_d && temp_alarm_out;
    evt[STS_UPDATED]   = upd_go;
    clr = (wr_en && aw_idx_q == IDX_IRQ_CLR) ? wbyte_q[STS_W-1:0] : STS_RST;
    // A new event beats a clear in the same cycle
    sts_d = (sts_q & ~clr) | evt;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sts_q   <= STS_RST;
      irq_out <= 1'b0;
    end else begin
      sts_q   <= sts_d;
      irq_out <= |(sts_d & irq_en_d);
    end
  end

  // --------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------
  always_comb begin
    rd_data = '0;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr_in[ADDR_W-1:2])
      IDX_EXT_LO:  rd_data[7:0] = shd_q.ext[7:0];
      IDX_EXT_HI:  rd_data[7:0] = shd_q.ext[15:8];
      IDX_SRC:     rd_data[7:0] = {RSVD_VAL, src_q.ch1, src_q.ch0, src_q.sys};
      IDX_LOW_LO:  rd_data[7:0] = shd_q.low[7:0];
      IDX_LOW_HI:  rd_data[7:0] = shd_q.low[15:8];
      IDX_HIGH_LO: rd_data[7:0] = shd_q.high[7:0];
      IDX_HIGH_HI: rd_data[7:0] = shd_q.high[15:8];
      IDX_STATUS:  rd_data[STS_LIVE_BIT:0] = {temp_alarm_out, sts_q};
      IDX_IRQ_EN:  rd_data[STS_W-1:0] = irq_en_q;
      IDX_SENS_LO: rd_data[7:0] = temp_sensor_in[7:0];
      IDX_SENS_HI: rd_data[7:0] = temp_sensor_in[15:8];
      IDX_UPDATE, IDX_IRQ_CLR: rd_data = '0;
      default:     rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= '0;
      s_axi_rresp_out   <= RESP_OKAY;
      rd_idx_q          <= '0;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= rd_data;
      s_axi_rresp_out   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rd_idx_q          <= s_axi_araddr_in[ADDR_W-1:2];
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  property p_ch1_src;
    @(posedge sys_clk_in) disable iff (rst_in)
    1'b1 |=> phase_loop_channel_one_temp_out ==
             ($past(src_q.ch1) ? $past(act_q.ext) : $past(temp_sensor_in));
  endproperty
  a_ch1_src: assert property (p_ch1_src) else $error("ch1 source wrong");

  property p_ch0_src;
    @(posedge sys_clk_in) disable iff (rst_in)
    src_q.ch0 |=> phase_loop_channel_zero_temp_out == $past(act_q.ext);
  endproperty
  a_ch0_src: assert property (p_ch0_src) else $error("ch0 source wrong");

  property p_sys_src;
    @(posedge sys_clk_in) disable iff (rst_in)
    (!src_q.sys ##1 !$past(src_q.sys)) |->
      system_clock_path_temp_out == $past(temp_sensor_in);
  endproperty
  a_sys_src: assert property (p_sys_src) else $error("sys source wrong");

  property p_rsvd_zero;
    @(posedge sys_clk_in) disable iff (rst_in)
    (s_axi_rvalid_out && rd_idx_q == IDX_SRC) |-> s_axi_rdata_out[7:3] == RSVD_VAL;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

  property p_low_byte;
    @(posedge sys_clk_in) disable iff (rst_in)
    (wr_en && aw_idx_q == IDX_LOW_HI) |=> shd_q.low[15:8] == $past(wbyte_q);
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low high byte lost");

  property p_buffered;
    @(posedge sys_clk_in) disable iff (rst_in)
    !upd_go |=> $stable(act_q);
  endproperty
  a_buffered: assert property (p_buffered) else $error("active moved early");

  property p_update;
    @(posedge sys_clk_in) disable iff (rst_in)
    upd_go |=> act_q.high == $past(shd_q.high) && act_q.low == $past(shd_q.low);
  endproperty
  a_update: assert property (p_update) else $error("update not applied");

  property p_signed;
    @(posedge sys_clk_in) disable iff (rst_in)
    (temp_sensor_in[15] && !act_q.low[15]) |=> temp_alarm_out;
  endproperty
  a_signed: assert property (p_signed) else $error("signed compare wrong");

  property p_alarm;
    @(posedge sys_clk_in) disable iff (rst_in)
    ($signed(temp_sensor_in) >= $signed(act_q.low) &&
     $signed(temp_sensor_in) <= $signed(act_q.high)) |=> !temp_alarm_out;
  endproperty
  a_alarm: assert property (p_alarm) else $error("false alarm");

  property p_irq;
    @(posedge sys_clk_in) disable iff (rst_in)
    1'b1 |-> irq_out == |(sts_q & irq_en_q);
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  c_update: cover property (@(posedge sys_clk_in) disable iff (rst_in) upd_go);
  c_alarm_on: cover property (@(posedge sys_clk_in) disable iff (rst_in)
                              $rose(temp_alarm_out));
  c_ext_sel: cover property (@(posedge sys_clk_in) disable iff (rst_in)
                             src_q.ch1 && src_q.ch0 && src_q.sys);
  c_irq: cover property (@(posedge sys_clk_in) disable iff (rst_in) $rose(irq_out));
endmodule // tca_top

// file: shared/tca_pkg.sv
// Operation
// - Bit 2 picks channel-one phase compensation source
// - Bit 1 picks channel-zero phase compensation source
// - Bit 0 picks system clock compensation source
// - Select bits 7..3 reserved, read zero
// - Signed 16-bit low threshold in two bytes
// - Q8.7 fixed point, degrees times 128
// - Threshold bytes buffered until update command
// - Buffered signed 16-bit high threshold likewise
package tca_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 14;
  localparam int TEMP_W = 16;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_EXT_LO  = 14'h2900;
  localparam logic [IDX_W-1:0] IDX_EXT_HI  = 14'h2901;
  localparam logic [IDX_W-1:0] IDX_SRC     = 14'h2902;
  localparam logic [IDX_W-1:0] IDX_LOW_LO  = 14'h2903;
  localparam logic [IDX_W-1:0] IDX_LOW_HI  = 14'h2904;
  localparam logic [IDX_W-1:0] IDX_HIGH_LO = 14'h2905;
  localparam logic [IDX_W-1:0] IDX_HIGH_HI = 14'h2906;
  localparam logic [IDX_W-1:0] IDX_UPDATE  = 14'h2910;
  localparam logic [IDX_W-1:0] IDX_STATUS  = 14'h2911;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN  = 14'h2912;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 14'h2913;
  localparam logic [IDX_W-1:0] IDX_SENS_LO = 14'h2914;
  localparam logic [IDX_W-1:0] IDX_SENS_HI = 14'h2915;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int UPD_BIT       = 0;
  localparam int STS_W         = 3;
  localparam int STS_ALARM_ON  = 0;
  localparam int STS_ALARM_OFF = 1;
  localparam int STS_UPDATED   = 2;
  localparam int STS_LIVE_BIT  = 3;
  localparam logic [7:0]        SRC_RST  = 8'h00;
  localparam logic [4:0]        RSVD_VAL = 5'h00;
  localparam logic [TEMP_W-1:0] TEMP_RST = 16'h0000;
  localparam logic [STS_W-1:0]  STS_RST  = 3'h0;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [4:0] rsvd;
    logic       ch1;
    logic       ch0;
    logic       sys;
  } tca_src_t;

  typedef struct packed {
    logic [TEMP_W-1:0] ext;
    logic [TEMP_W-1:0] low;
    logic [TEMP_W-1:0] high;
  } tca_temps_t;
endpackage
